/* hdl/logic_fabric_cell.sv */
// configurable logic cells with pad cells, scan chain and apb configuration
//
// Functional notes
// - cell: two 6-AND, four 2-AND, three muxes, flop
// - gating up to 14 wide, any 3-variable function
// - mux tree output feeds flop data input
// - separate set and reset force output at once
// - jk, sr, t, counter via gating and feedback
// - five separate outputs per cell
// - undriven inputs tied to constant one or zero
// - pad driven from 2-or through enabled buffer
// - pad active high, active low, open drain
// - input cell gives true and complement
// - clock tree pad reaches set and reset; flops clock on i_clk
// - all cell flops form a serial scan path
`timescale 1ns/1ns
module logic_fabric_cell #(
    parameter int NUM_CELLS = 2
) (
    input  wire logic                                  i_clk,
    input  wire logic                                  i_rst_n,
    // apb slave
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [11:0]                           paddr,
    input  wire logic [31:0]                           pwdata,
    output logic      [31:0]                           prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    // routing into and out of the cell array
    input  wire logic [NUM_CELLS-1:0][fabric_pkg::NUM_IN-1:0] i_cell_in,
    output fabric_pkg::cell_out_t [NUM_CELLS-1:0]      o_cell_out,
    // clock tree pad, used as set or reset source
    input  wire logic                                  i_tree_pad,
    // bidirectional pad cell
    input  wire logic                                  i_io_or_a,
    input  wire logic                                  i_io_or_b,
    input  wire logic                                  i_io_en,
    input  wire logic                                  i_io_pad_i,
    output logic                                       o_io_pad_o,
    output logic                                       o_io_pad_oe_n,
    output logic                                       o_io_to_array,
    // dedicated input cell
    input  wire logic                                  i_in_pad,
    output logic                                       o_in_true,
    output logic                                       o_in_comp,
    // scan path
    input  wire logic                                  i_scan_in,
    output logic                                       o_scan_out
);

    typedef struct packed {
        logic [31:0]                          ctrl;
        fabric_pkg::cell_cfg_t [NUM_CELLS-1:0] cfg;
        logic [NUM_CELLS-1:0]                 q;
        logic [31:0]                          rdata;
        logic                                 slverr;
        logic                                 in_true;
        logic                                 in_comp;
        logic                                 io_in;
    } state_t;

    state_t state;
    state_t next_state;

    // decode: 0 none, 1 ctrl, 2 status, 3 cell register; cell and slot out
    function automatic logic [1:0] reg_kind(input logic [11:0] addr);
        logic [11:0] top;
        top = 12'(fabric_pkg::CELL_BASE + NUM_CELLS * fabric_pkg::CELL_STRIDE);
        if (addr[1:0] != 2'h0) begin
            reg_kind = 2'h0;
        end else if (addr == fabric_pkg::CTRL_ADDR) begin
            reg_kind = 2'h1;
        end else if (addr == fabric_pkg::STATUS_ADDR) begin
            reg_kind = 2'h2;
        end else if (addr >= fabric_pkg::CELL_BASE && addr < top) begin
            reg_kind = 2'h3;
        end else begin
            reg_kind = 2'h0;
        end
    endfunction

    function automatic int cell_idx(input logic [11:0] addr);
        logic [11:0] off;
        off = addr - fabric_pkg::CELL_BASE;
        cell_idx = int'(off[11:4]);
    endfunction

    // condition one raw input: feedback, constant tie, polarity
    function automatic logic [21:0] shape_in(
        input logic [21:0]           raw,
        input logic                  q,
        input fabric_pkg::cell_cfg_t c
    );
        logic [21:0] v;
        v = (raw & ~c.feedback) | ({22{q}} & c.feedback);
        v = (v & ~c.tie_mask) | (c.tie_val & c.tie_mask);
        shape_in = v ^ c.invert;
    endfunction

    // combinational part of one cell
    function automatic fabric_pkg::cell_out_t cell_eval(input logic [21:0] x);
        logic a_and;
        logic f_and;
        logic b_and;
        logic c_and;
        logic d_and;
        logic e_and;
        logic m1;
        logic m2;
        fabric_pkg::cell_out_t r;
        a_and = &x[fabric_pkg::A_LO +: fabric_pkg::WIDE_W];
        f_and = &x[fabric_pkg::F_LO +: fabric_pkg::WIDE_W];
        b_and = &x[fabric_pkg::B_LO +: fabric_pkg::NARROW_W];
        c_and = &x[fabric_pkg::C_LO +: fabric_pkg::NARROW_W];
        d_and = &x[fabric_pkg::D_LO +: fabric_pkg::NARROW_W];
        e_and = &x[fabric_pkg::E_LO +: fabric_pkg::NARROW_W];
        // two first-level muxes steered by the a gate
        m1 = a_and ? c_and : b_and;
        m2 = a_and ? e_and : d_and;
        r.az = a_and;
        r.fz = f_and;
        r.nz = m2;
        // final mux steered by f: a, f and e tied give 14-wide and
        r.oz = f_and ? m2 : m1;
        r.qz = 1'b0;
        cell_eval = r;
    endfunction

    // pick a set or reset source
    function automatic logic sr_pick(
        input fabric_pkg::sr_src_t s,
        input logic                pin,
        input logic                tree
    );
        unique case (s)
            fabric_pkg::SR_NONE: sr_pick = 1'b0;
            fabric_pkg::SR_CELL: sr_pick = pin;
            fabric_pkg::SR_TREE: sr_pick = tree;
            default:             sr_pick = 1'b0;
        endcase
    endfunction

    // per cell evaluated signals
    logic [NUM_CELLS-1:0][21:0]       cell_x;
    fabric_pkg::cell_out_t [NUM_CELLS-1:0] cell_comb;
    logic [NUM_CELLS-1:0]             cell_set;
    logic [NUM_CELLS-1:0]             cell_rst;
    logic [NUM_CELLS-1:0]             q_shown;
    logic [NUM_CELLS:0]               scan_chain;

    // cell array: gating, muxes and set/reset that act without waiting for a clock
    always_comb begin
        for (int k = 0; k < NUM_CELLS; k++) begin
            // feedback from the stored bit: taking qz here would loop through set/reset
            cell_x[k]    = shape_in(i_cell_in[k], state.q[k], state.cfg[k]);
            cell_comb[k] = cell_eval(cell_x[k]);
            cell_set[k]  = sr_pick(state.cfg[k].set_src,
                                   cell_x[k][fabric_pkg::QS_POS], i_tree_pad);
            cell_rst[k]  = sr_pick(state.cfg[k].rst_src,
                                   cell_x[k][fabric_pkg::QR_POS], i_tree_pad);
        end
    end

    // visible flop output: reset over set over stored value
    always_comb begin
        for (int k = 0; k < NUM_CELLS; k++) begin
            if (cell_rst[k]) begin
                q_shown[k] = 1'b0;
            end else if (cell_set[k]) begin
                q_shown[k] = 1'b1;
            end else begin
                q_shown[k] = state.q[k];
            end
        end
    end

    // scan source of each cell: serial input first, then previous cell
    assign scan_chain = {q_shown, i_scan_in};

    // five outputs per cell, qz free of the and gates
    always_comb begin
        for (int k = 0; k < NUM_CELLS; k++) begin
            o_cell_out[k]    = cell_comb[k];
            o_cell_out[k].qz = q_shown[k];
        end
    end

    // pad cell: or gate, enable, polarity and open drain
    logic                  io_or;
    fabric_pkg::pad_mode_t io_mode;
    fabric_pkg::pad_drive_t io_drv;

    always_comb begin
        io_or   = i_io_or_a | i_io_or_b;
        io_mode = fabric_pkg::pad_mode_t'(state.ctrl[fabric_pkg::CTRL_MODE_LO +: 2]);
        io_drv.pad_o    = 1'b0;
        io_drv.pad_oe_n = 1'b1;
        unique case (io_mode)
            fabric_pkg::PAD_ACT_HIGH: begin
                io_drv.pad_o    = io_or;
                io_drv.pad_oe_n = ~i_io_en;
            end
            fabric_pkg::PAD_ACT_LOW: begin
                io_drv.pad_o    = ~io_or;
                io_drv.pad_oe_n = ~i_io_en;
            end
            fabric_pkg::PAD_OPEN_DRN: begin
                // inverting: pull low on a one, float otherwise
                io_drv.pad_o    = 1'b0;
                io_drv.pad_oe_n = ~(i_io_en & io_or);
            end
            default: begin
                io_drv.pad_o    = 1'b0;
                io_drv.pad_oe_n = 1'b1;
            end
        endcase
    end

    assign o_io_pad_o    = io_drv.pad_o;
    assign o_io_pad_oe_n = io_drv.pad_oe_n;

    // apb decode for this access
    logic [1:0] kind;
    int         cidx;
    logic       wr_go;
    logic       rd_go;
    logic       scan_on;

    always_comb begin
        kind    = reg_kind(paddr);
        cidx    = (kind == 2'h3) ? cell_idx(paddr) : 0;
        wr_go   = psel & ~penable & pwrite;
        rd_go   = psel & ~penable & ~pwrite;
        scan_on = state.ctrl[fabric_pkg::CTRL_SCAN_POS];
    end

    // next state: registers, cell flops, pad samples
    always_comb begin
        next_state = state;
        // cell flops capture the mux output or the scan chain
        for (int k = 0; k < NUM_CELLS; k++) begin
            if (scan_on) begin
                next_state.q[k] = scan_chain[k];
            end else begin
                next_state.q[k] = cell_comb[k].oz;
            end
            // a held set or reset keeps the stored value forced as well
            if (cell_rst[k]) begin
                next_state.q[k] = 1'b0;
            end else if (cell_set[k]) begin
                next_state.q[k] = 1'b1;
            end
        end
        // dedicated input and pad input into the array
        next_state.in_true = i_in_pad;
        next_state.in_comp = ~i_in_pad;
        next_state.io_in   = i_io_pad_i;
        // registers answer in the setup cycle, ready in access cycle
        if (wr_go) begin
            next_state.slverr = (kind == 2'h0) || (kind == 2'h2);
            if (kind == 2'h1) begin
                next_state.ctrl = {29'h0, pwdata[2:0]};
            end else if (kind == 2'h3) begin
                unique case (paddr[3:2])
                    fabric_pkg::TIE_MASK_W: next_state.cfg[cidx].tie_mask = pwdata[21:0];
                    fabric_pkg::TIE_VAL_W:  next_state.cfg[cidx].tie_val  = pwdata[21:0];
                    fabric_pkg::INVERT_W:   next_state.cfg[cidx].invert   = pwdata[21:0];
                    fabric_pkg::ROUTE_W: begin
                        next_state.cfg[cidx].feedback = pwdata[21:0];
                        next_state.cfg[cidx].set_src  =
                            fabric_pkg::sr_src_t'(pwdata[fabric_pkg::ROUTE_SET_LO +: 2]);
                        next_state.cfg[cidx].rst_src  =
                            fabric_pkg::sr_src_t'(pwdata[fabric_pkg::ROUTE_RST_LO +: 2]);
                    end
                endcase
            end
        end else if (rd_go) begin
            next_state.slverr = (kind == 2'h0);
            next_state.rdata  = 32'h0000_0000;
            unique case (kind)
                2'h1: next_state.rdata = state.ctrl;
                2'h2: next_state.rdata = {29'h0, state.in_true, state.io_in, 1'b0}
                                         | 32'(q_shown) << 8;
                2'h3: begin
                    unique case (paddr[3:2])
                        fabric_pkg::TIE_MASK_W: next_state.rdata = {10'h0, state.cfg[cidx].tie_mask};
                        fabric_pkg::TIE_VAL_W:  next_state.rdata = {10'h0, state.cfg[cidx].tie_val};
                        fabric_pkg::INVERT_W:   next_state.rdata = {10'h0, state.cfg[cidx].invert};
                        fabric_pkg::ROUTE_W:    next_state.rdata = {6'h0,
                            state.cfg[cidx].rst_src, state.cfg[cidx].set_src,
                            state.cfg[cidx].feedback};
                    endcase
                end
                default: next_state.rdata = 32'h0000_0000;
            endcase
        end
    end

    // one register stage for all state, synchronous reset
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state.ctrl    <= fabric_pkg::CTRL_RESET;
            for (int k = 0; k < NUM_CELLS; k++) begin
                state.cfg[k].tie_mask <= fabric_pkg::MASK_RESET;
                state.cfg[k].tie_val  <= fabric_pkg::ZERO_22;
                state.cfg[k].invert   <= fabric_pkg::ZERO_22;
                state.cfg[k].feedback <= fabric_pkg::ZERO_22;
                state.cfg[k].set_src  <= fabric_pkg::SR_NONE;
                state.cfg[k].rst_src  <= fabric_pkg::SR_NONE;
            end
            state.q       <= '0;
            state.rdata   <= 32'h0000_0000;
            state.slverr  <= 1'b0;
            state.in_true <= 1'b0;
            state.in_comp <= 1'b1;
            state.io_in   <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // bus and registered outputs
    assign prdata        = state.rdata;
    assign pslverr       = state.slverr & psel & penable;
    assign pready        = 1'b1;       // zero wait states
    assign o_in_true     = state.in_true;
    assign o_in_comp     = state.in_comp;
    assign o_io_to_array = state.io_in;
    assign o_scan_out    = q_shown[NUM_CELLS-1];

endmodule // logic_fabric_cell

/* hdl/fabric_pkg.sv */
// shared constants and types for the configurable logic cell block
package fabric_pkg;
    // cell input positions inside one input vector
    localparam int NUM_IN   = 22;
    localparam int A_LO     = 0;
    localparam int F_LO     = 6;
    localparam int B_LO     = 12;
    localparam int C_LO     = 14;
    localparam int D_LO     = 16;
    localparam int E_LO     = 18;
    localparam int QS_POS   = 20;
    localparam int QR_POS   = 21;
    localparam int WIDE_W   = 6;
    localparam int NARROW_W = 2;

    // register map, byte addresses
    localparam logic [11:0] CTRL_ADDR   = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;
    localparam logic [11:0] CELL_BASE   = 12'h010;
    localparam logic [11:0] CELL_STRIDE = 12'h010;
    localparam logic [1:0]  TIE_MASK_W  = 2'h0;
    localparam logic [1:0]  TIE_VAL_W   = 2'h1;
    localparam logic [1:0]  INVERT_W    = 2'h2;
    localparam logic [1:0]  ROUTE_W     = 2'h3;

    // field positions
    localparam int CTRL_MODE_LO  = 0;
    localparam int CTRL_SCAN_POS = 2;
    localparam int ROUTE_SET_LO  = 22;
    localparam int ROUTE_RST_LO  = 24;

    // reset values: every input tied low, no inversion, no feedback
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [21:0] MASK_RESET = 22'h3f_ffff;
    localparam logic [21:0] ZERO_22    = 22'h00_0000;

    // pad output driver modes
    typedef enum logic [1:0] {
        PAD_ACT_HIGH  = 2'h0,
        PAD_ACT_LOW   = 2'h1,
        PAD_OPEN_DRN  = 2'h2
    } pad_mode_t;

    // flip-flop set and reset sources
    typedef enum logic [1:0] {
        SR_NONE = 2'h0,
        SR_CELL = 2'h1,
        SR_TREE = 2'h2
    } sr_src_t;

    // per cell configuration
    typedef struct packed {
        logic [21:0] tie_mask;
        logic [21:0] tie_val;
        logic [21:0] invert;
        logic [21:0] feedback;
        sr_src_t     set_src;
        sr_src_t     rst_src;
    } cell_cfg_t;

    // five outputs of one cell
    typedef struct packed {
        logic az;
        logic fz;
        logic nz;
        logic oz;
        logic qz;
    } cell_out_t;

    // pad drive towards the board
    typedef struct packed {
        logic pad_o;
        logic pad_oe_n;
    } pad_drive_t;
endpackage

/* dv/board_pads.sv */
// board side of the bidirectional pad: pull-up plus an optional external driver
`timescale 1ns/1ns
module board_pads (
    input  wire logic i_pad_o,
    input  wire logic i_pad_oe_n,
    input  wire logic i_ext_en,
    input  wire logic i_ext_val,
    output logic      o_level
);
    // released line rises to the pull-up; a clash of drivers reads low, as on a real wire-and
    assign o_level = (!i_pad_oe_n ? i_pad_o : 1'b1) & (i_ext_en ? i_ext_val : 1'b1);
endmodule // board_pads

/* dv/logic_fabric_cell_checker.sv */
// port assertions for the logic fabric block
`timescale 1ns/1ns
module logic_fabric_cell_checker #(
    parameter int NUM_CELLS = 2
) (
    input wire logic                                  i_clk,
    input wire logic                                  i_rst_n,
    input wire logic                                  psel,
    input wire logic                                  penable,
    input wire logic                                  pwrite,
    input wire logic [11:0]                           paddr,
    input wire logic [31:0]                           prdata,
    input wire logic                                  pready,
    input wire logic                                  pslverr,
    input wire fabric_pkg::cell_out_t [NUM_CELLS-1:0] o_cell_out,
    input wire logic                                  i_io_or_a,
    input wire logic                                  i_io_or_b,
    input wire logic                                  i_io_en,
    input wire logic                                  i_io_pad_i,
    input wire logic                                  o_io_pad_oe_n,
    input wire logic                                  o_io_to_array,
    input wire logic                                  i_in_pad,
    input wire logic                                  o_in_true,
    input wire logic                                  o_in_comp,
    input wire logic                                  o_scan_out
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // bus answers
    a_ready_access: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    a_slverr_phase: assert property (pslverr |-> psel && penable)
        else $error("error flag outside access phase");
    a_unaligned_err: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access not refused");
    a_status_ro: assert property (psel && penable && pwrite
                                  && paddr == fabric_pkg::STATUS_ADDR |-> pslverr)
        else $error("status write not refused");
    // read data moves only after a read setup, never on its own
    a_rdata_hold: assert property ($changed(prdata) && $past(i_rst_n)
                                   |-> $past(psel && !penable && !pwrite))
        else $error("read data changed without a read");
    // pad cells: one cycle of registering, skipped over the reset edge
    a_pad_sample: assert property ($past(i_rst_n) |-> o_io_to_array == $past(i_io_pad_i))
        else $error("pad level not registered");
    a_in_sample: assert property ($past(i_rst_n) |->
                                  o_in_true == $past(i_in_pad) && o_in_comp == !o_in_true)
        else $error("input cell pair wrong");
    a_oe_needs_en: assert property (!o_io_pad_oe_n |-> i_io_en)
        else $error("pad driven while disabled");
    // with enable high the open-drain mode releases only for a low or; mode 3 releases for any or
    a_od_release: assert property (i_io_en && o_io_pad_oe_n |-> !(i_io_or_a || i_io_or_b))
        else $error("pad released with enable and or high");
    a_scan_tap: assert property (o_scan_out == o_cell_out[NUM_CELLS-1].qz)
        else $error("scan out is not the last cell");
endmodule // logic_fabric_cell_checker

bind logic_fabric_cell logic_fabric_cell_checker #(.NUM_CELLS(NUM_CELLS)) u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .o_cell_out(o_cell_out), .i_io_or_a(i_io_or_a), .i_io_or_b(i_io_or_b),
    .i_io_en(i_io_en), .i_io_pad_i(i_io_pad_i), .o_io_pad_oe_n(o_io_pad_oe_n),
    .o_io_to_array(o_io_to_array), .i_in_pad(i_in_pad), .o_in_true(o_in_true),
    .o_in_comp(o_in_comp), .o_scan_out(o_scan_out));

/* dv/logic_fabric_cell_test.sv */
// self-checking bench for the logic fabric block
`timescale 1ns/1ns
module logic_fabric_cell_test;
    localparam int NC = 2;
    logic                           i_clk, i_rst_n, psel, penable, pwrite;
    logic [11:0]                    paddr;
    logic [31:0]                    pwdata, prdata;
    logic                           pready, pslverr, tree_pad, or_a, or_b, io_en;
    logic [NC-1:0][21:0]            cell_in;
    fabric_pkg::cell_out_t [NC-1:0] cell_out;
    logic                           pad_lvl, pad_o, pad_oe_n, to_array, ext_en, ext_val;
    logic                           in_pad, in_true, in_comp, scan_in, scan_out;
    int                             fails, cmp_count;

    logic_fabric_cell #(.NUM_CELLS(NC)) DUT (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_cell_in(cell_in), .o_cell_out(cell_out),
        .i_tree_pad(tree_pad), .i_io_or_a(or_a), .i_io_or_b(or_b), .i_io_en(io_en),
        .i_io_pad_i(pad_lvl), .o_io_pad_o(pad_o), .o_io_pad_oe_n(pad_oe_n),
        .o_io_to_array(to_array), .i_in_pad(in_pad), .o_in_true(in_true),
        .o_in_comp(in_comp), .i_scan_in(scan_in), .o_scan_out(scan_out));

    board_pads board (.i_pad_o(pad_o), .i_pad_oe_n(pad_oe_n), .i_ext_en(ext_en),
                      .i_ext_val(ext_val), .o_level(pad_lvl));

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic complete_run;
        if (fails == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    // one apb transfer; the request stands until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] want);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, want);
    endtask

    // refused access: error flag expected in the access phase
    task automatic errc(input logic w, input logic [11:0] a);
        logic [31:0] r;
        logic        e;
        apb(w, a, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
    endtask

    function automatic logic [11:0] ca(input int k, input logic [1:0] r);
        return fabric_pkg::CELL_BASE + fabric_pkg::CELL_STRIDE * k[11:0] + {8'h0, r, 2'h0};
    endfunction

    // hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (3000) @(posedge i_clk);
        fails++;
        complete_run();
    end

    initial begin
        logic       a, f, b, c, d, g, m1, m2, oz, prev, e, ox, oex;
        logic [7:0] pat;
        {i_rst_n, psel, penable, pwrite, tree_pad, or_a, or_b, io_en} = '0;
        {ext_en, ext_val, in_pad, scan_in, paddr, pwdata} = '0;
        cell_in = '1;
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        // reset contents; all-ones routing must not reach tied inputs
        rdc(fabric_pkg::CTRL_ADDR, fabric_pkg::CTRL_RESET);
        rdc(ca(0, fabric_pkg::TIE_MASK_W), {10'h0, fabric_pkg::MASK_RESET});
        rdc(ca(1, fabric_pkg::ROUTE_W), 32'h0);
        rdc(fabric_pkg::STATUS_ADDR, 32'h0000_0002);
        chk({28'h0, cell_out[0][4:1]}, 32'h0);
        errc(1'b0, 12'h008);
        errc(1'b1, fabric_pkg::STATUS_ADDR);
        errc(1'b1, 12'h012);
        // every select/data mix, one low bit walking through the wide gates
        wr(ca(0, fabric_pkg::TIE_MASK_W), 32'h0);
        for (int i = 0; i < 64; i++) begin
            {g, d, c, b, f, a} = i[5:0];
            cell_in[0] <= {2'h0, {2{g}}, {2{d}}, {2{c}}, {2{b}},
                           f ? 6'h3f : ~(6'h20 >> (i % 6)), a ? 6'h3f : ~(6'h01 << (i % 6))};
            @(posedge i_clk);
            if (i > 0) chk({31'h0, cell_out[0].qz}, {31'h0, prev});
            m1 = a ? c : b;
            m2 = a ? g : d;
            oz = f ? m2 : m1;
            chk({28'h0, cell_out[0][4:1]}, {28'h0, a, f, m2, oz});
            prev = oz;
        end
        // set from the tree pad, reset from the cell pin, both at once
        cell_in[0] <= '0;
        wr(ca(0, fabric_pkg::ROUTE_W),
           {6'h0, fabric_pkg::SR_CELL, fabric_pkg::SR_TREE, 22'h0});
        tree_pad <= 1'b1;
        @(posedge i_clk);
        chk({31'h0, cell_out[0].qz}, 32'h1);
        cell_in[0][fabric_pkg::QR_POS] <= 1'b1;
        @(posedge i_clk);
        chk({31'h0, cell_out[0].qz}, 32'h0);
        tree_pad <= 1'b0;
        cell_in[0] <= '0;
        // pad: each mode against every or input and enable
        for (int i = 0; i < 24; i++) begin
            wr(fabric_pkg::CTRL_ADDR, {30'h0, 2'(i / 8)});
            {io_en, or_a, or_b} <= 3'(i % 8);
            @(posedge i_clk);
            e = or_a | or_b;
            ox = (i / 8 == 0) ? e : (i / 8 == 1) ? !e : 1'b0;
            oex = (i / 8 == 2) ? !(io_en && e) : !io_en;
            chk({30'h0, pad_o, pad_oe_n}, {30'h0, ox, oex});
            @(posedge i_clk);
            chk({31'h0, to_array}, {31'h0, oex | ox});
        end
        // released pad used as input from the board
        wr(fabric_pkg::CTRL_ADDR, 32'h0);
        io_en <= 1'b0;
        ext_en <= 1'b1;
        in_pad <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk({31'h0, to_array}, 32'h0);
        chk({30'h0, in_true, in_comp}, 32'h2);
        rdc(fabric_pkg::STATUS_ADDR, 32'h0000_0004);
        // scan: a bit needs one edge per cell to reach the tap
        pat = 8'hb2;
        wr(fabric_pkg::CTRL_ADDR, 32'h4);
        for (int j = 0; j < 8; j++) begin
            scan_in <= pat[j];
            @(posedge i_clk);
            if (j >= NC) chk({31'h0, scan_out}, {31'h0, pat[j-NC]});
        end
        // toggle storage: cell 1 feeds its inverted bit back through the b gate
        wr(fabric_pkg::CTRL_ADDR, 32'h0);
        wr(ca(1, fabric_pkg::TIE_VAL_W), 32'h0000_2000);
        wr(ca(1, fabric_pkg::INVERT_W), 32'h0000_1000);
        wr(ca(1, fabric_pkg::ROUTE_W), 32'h0000_1000);
        wr(ca(1, fabric_pkg::TIE_MASK_W), 32'h003f_efff);
        for (int j = 0; j < 4; j++) begin
            prev = cell_out[1].qz;
            @(posedge i_clk);
            chk({31'h0, cell_out[1].qz}, {31'h0, !prev});
        end
        complete_run();
    end
endmodule // logic_fabric_cell_test
